// [shared/gp_pkg.sv]
package gp_pkg;

  // port geometry
  localparam int GP_PINS    = 8;
  localparam int GP_SRCS    = 9;
  localparam int GP_DMA_BIT = 8;

  // detection modes, as written and read back per pin
  typedef enum logic [2:0]
  {
    gp_det_fall = 3'h0,
    gp_det_rise = 3'h1,
    gp_det_both = 3'h2,
    gp_det_low  = 3'h3,
    gp_det_high = 3'h4
  } gp_det_mode_t;

  // drive strength codes; the last three exist on wide-drive variants only
  typedef enum logic [2:0]
  {
    gp_drive_2ma               = 3'h0,
    gp_drive_4ma               = 3'h1,
    gp_drive_8ma               = 3'h2,
    gp_drive_mid_slew_limited  = 3'h3,
    gp_drive_6ma               = 3'h4,
    gp_drive_10ma              = 3'h5,
    gp_drive_12ma              = 3'h6
  } gp_drive_t;

  // pad type codes; wake codes exist on hibernate-capable variants only
  typedef enum logic [2:0]
  {
    gp_pad_push_pull          = 3'h0,
    gp_pad_push_pull_pullup   = 3'h1,
    gp_pad_push_pull_pulldown = 3'h2,
    gp_pad_open_drain         = 3'h3,
    gp_pad_analog             = 3'h4,
    gp_pad_wake_high          = 3'h5,
    gp_pad_wake_low           = 3'h6
  } gp_pad_t;

  // reset values
  localparam gp_det_mode_t GP_MODE_RST  = gp_det_fall;
  localparam gp_drive_t    GP_DRIVE_RST = gp_drive_2ma;
  localparam gp_pad_t      GP_PAD_RST   = gp_pad_push_pull;
  localparam logic [8:0]   GP_IEN_RST   = 9'h000;
  localparam logic [7:0]   GP_COMMIT_RST = 8'h00;

  // pins guarded against accidental reconfiguration
  localparam logic [7:0]   GP_PROT_PINS  = 8'h0f;
  // unlock key for the lock port
  localparam logic [31:0]  GP_UNLOCK_KEY = 32'h5a5a_c3c3;
  // this port offers per-pin discrete interrupt lines
  localparam logic         GP_DISCRETE_CAP = 1'b1;

  // cycles until synchroniser and edge history hold real pin data
  localparam logic [1:0]   GP_SYNC_FILL = 2'h3;

endpackage

// [shared/gp_det_if.sv]
`timescale 1ns/1ps
interface gp_det_if;
  import gp_pkg::*;
  logic         sample;
  gp_det_mode_t mode;
  logic         ready;
  logic         clr;
  logic         raw;
  modport det (input sample, input mode, input ready, input clr, output raw);
  modport ctl (output sample, output mode, output ready, output clr, input raw);
endinterface

// [logic/gp_pin_det.sv]
`timescale 1ns/1ps
module gp_pin_det
  import gp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  gp_det_if.det    bus
);

  typedef struct packed
  {
    logic prev;
    logic pend;
    logic raw;
  } gp_det_state_t;

  gp_det_state_t st_reg;
  gp_det_state_t st_next;

  // edge/level detection for one pin
  always_comb
  begin
    logic rise;
    logic fall;
    logic hit;
    logic lvl;
    logic is_lvl;
    rise    = 1'b0;
    fall    = 1'b0;
    hit     = 1'b0;
    lvl     = 1'b0;
    is_lvl  = 1'b0;
    st_next = st_reg;
    rise    = bus.sample & ~st_reg.prev;
    fall    = ~bus.sample & st_reg.prev;
    case (bus.mode)
      gp_det_fall: hit = fall;
      gp_det_rise: hit = rise;
      gp_det_both: hit = rise | fall;
      gp_det_low:
      begin
        is_lvl = 1'b1;
        lvl    = ~bus.sample;
      end
      gp_det_high:
      begin
        is_lvl = 1'b1;
        lvl    = bus.sample;
      end
      default: hit = 1'b0;
    endcase
    st_next.prev = bus.sample;
    // edge stays pending until cleared; a new edge beats a same-cycle clear
    if (is_lvl)
      st_next.pend = 1'b0;
    else
      st_next.pend = (st_reg.pend & ~bus.clr) | (bus.ready & hit);
    // level source follows the pin, clear cannot hide it
    st_next.raw = is_lvl ? (bus.ready & lvl) : st_next.pend;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign bus.raw = st_reg.raw;

endmodule

// [logic/gp_port.sv]
`timescale 1ns/1ps
// Summary of operation
// - a source reaches the interrupt output only while its enable bit is set
// - nine enableable sources: pins 0 to 7 plus port dma activity
// - status reads either raw sources or sources masked by enables
// - status has one bit per source, set while that source is active
// - each pin detects falling, rising, both edges, low or high level
// - a capable port may give each pin its own interrupt line
// - discrete off puts the summary on pin 0 line; other lines still fire
// - per-pin writes carry an eight-bit pin mask; only selected pins change
// - per-pin drive strength 2, 4, 8, 8 with slew, plus 6, 10, 12
// - per-pin pad type push-pull, pull-up, pull-down, open-drain or analog
// - a pin may be a hibernate wake source, sensing high or low
// - input pins store the full pad setting but only pulls, analog and wake act
// - pad readback returns the drive and pad codes last written
// - type readback returns detection mode plus the discrete flag if set
// - protected pins change only after lock key then commit writes
// - one port-level request goes to the processor interrupt controller
// - a clear write drops pending sources selected in its mask only
module gp_port
  import gp_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire logic [GP_PINS-1:0]       pin_in,
  input  wire logic [GP_PINS-1:0]       dir_in_mask,
  input  wire logic                     dma_event,
  input  wire logic                     ien_set_wr,
  input  wire logic                     ien_clr_wr,
  input  wire logic [GP_SRCS-1:0]       ien_flags,
  input  wire logic                     int_clr_wr,
  input  wire logic [GP_SRCS-1:0]       int_clr_flags,
  input  wire logic                     status_masked_sel,
  input  wire logic                     type_wr,
  input  wire logic [GP_PINS-1:0]       type_pins,
  input  wire logic [2:0]               type_mode,
  input  wire logic                     type_discrete,
  input  wire logic                     pad_wr,
  input  wire logic [GP_PINS-1:0]       pad_pins,
  input  wire logic [2:0]               pad_strength,
  input  wire logic [2:0]               pad_type,
  input  wire logic                     lock_wr,
  input  wire logic [31:0]              lock_key,
  input  wire logic                     commit_wr,
  input  wire logic [GP_PINS-1:0]       commit_pins,
  input  wire logic                     rd_req,
  input  wire logic [2:0]               rd_pin,
  output logic                          port_irq,
  output logic [GP_PINS-1:0]            pin_irq,
  output logic [GP_SRCS-1:0]            status_out,
  output logic [GP_SRCS-1:0]            ien_out,
  output logic                          unlocked_out,
  output logic [GP_PINS-1:0]            commit_out,
  output logic [GP_PINS-1:0][2:0]       pad_drive_out,
  output logic [GP_PINS-1:0]            pad_slew_en,
  output logic [GP_PINS-1:0]            pad_pullup_en,
  output logic [GP_PINS-1:0]            pad_pulldown_en,
  output logic [GP_PINS-1:0]            pad_od_en,
  output logic [GP_PINS-1:0]            pad_analog_en,
  output logic [GP_PINS-1:0]            wake_en,
  output logic [GP_PINS-1:0]            wake_sense_high,
  output logic                          rd_valid,
  output logic [2:0]                    rd_strength,
  output logic [2:0]                    rd_pad_type,
  output logic [2:0]                    rd_mode,
  output logic                          rd_discrete
);

  typedef struct packed
  {
    logic [GP_PINS-1:0]               sync1;
    logic [GP_PINS-1:0]               sync2;
    logic [1:0]                       fill;
    logic [GP_SRCS-1:0]               ien;
    logic                             dma_pend;
    gp_det_mode_t [GP_PINS-1:0]       mode;
    logic [GP_PINS-1:0]               disc;
    gp_drive_t [GP_PINS-1:0]          drive;
    gp_pad_t [GP_PINS-1:0]            ptype;
    logic                             unlocked;
    logic [GP_PINS-1:0]               commit;
    logic [GP_PINS-1:0]               clr_pins;
    logic                             port_irq;
    logic [GP_PINS-1:0]               pin_irq;
    logic [GP_SRCS-1:0]               status;
    logic [GP_PINS-1:0][2:0]          pad_drive;
    logic [GP_PINS-1:0]               slew_en;
    logic [GP_PINS-1:0]               pu_en;
    logic [GP_PINS-1:0]               pd_en;
    logic [GP_PINS-1:0]               od_en;
    logic [GP_PINS-1:0]               an_en;
    logic [GP_PINS-1:0]               wk_en;
    logic [GP_PINS-1:0]               wk_high;
    logic                             rd_valid;
    logic [2:0]                       rd_strength;
    logic [2:0]                       rd_pad_type;
    logic [2:0]                       rd_mode;
    logic                             rd_discrete;
  } gp_port_state_t;

  gp_port_state_t       st_reg;
  gp_port_state_t       st_next;
  logic [GP_PINS-1:0]   raw_pin;

  // pins a per-pin write may touch: selected, and unguarded or committed
  function automatic logic [GP_PINS-1:0] gp_wr_mask
  (
    input logic [GP_PINS-1:0] pins,
    input logic [GP_PINS-1:0] commit
  );
    gp_wr_mask = pins & (~GP_PROT_PINS | commit);
  endfunction

  // one detector per pin; each keeps its own edge history and pending bit
  genvar gi;
  generate
    for (gi = 0; gi < GP_PINS; gi++)
    begin : g_det
      gp_det_if det_bus ();
      assign det_bus.sample = st_reg.sync2[gi];
      assign det_bus.mode   = st_reg.mode[gi];
      assign det_bus.ready  = (st_reg.fill == GP_SYNC_FILL);
      assign det_bus.clr    = st_reg.clr_pins[gi];
      assign raw_pin[gi]    = det_bus.raw;
      gp_pin_det u_det
      (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .bus     (det_bus.det)
      );
    end
  endgenerate

  // next-state logic for the whole port
  always_comb
  begin
    logic [GP_SRCS-1:0] raw_all;
    logic [GP_SRCS-1:0] masked;
    logic [GP_PINS-1:0] tmask;
    logic [GP_PINS-1:0] pmask;
    logic               disc_on;
    raw_all = '0;
    masked  = '0;
    tmask   = '0;
    pmask   = '0;
    disc_on = 1'b0;
    st_next = st_reg;

    // two-stage synchroniser on the pins; only stage two is looked at
    st_next.sync1 = pin_in;
    st_next.sync2 = st_reg.sync1;
    // hold detection off until the edge history is filled from the pins,
    // otherwise a pin high at reset would look like a rising edge
    if (st_reg.fill != GP_SYNC_FILL)
      st_next.fill = st_reg.fill + 2'h1;

    // source enables; a disable and enable together leave the enable set
    if (ien_clr_wr)
      st_next.ien = st_next.ien & ~ien_flags;
    if (ien_set_wr)
      st_next.ien = st_next.ien | ien_flags;

    // clear strobes go to the detectors one cycle later, with the mask
    st_next.clr_pins = int_clr_wr ? int_clr_flags[GP_PINS-1:0] : '0;
    // dma activity sets its bit; an event in the clear cycle survives
    st_next.dma_pend = (st_reg.dma_pend & ~(int_clr_wr & int_clr_flags[GP_DMA_BIT]))
                     | dma_event;

    // lock port: right key opens, any other key closes and drops commits
    if (lock_wr)
    begin
      st_next.unlocked = (lock_key == GP_UNLOCK_KEY);
      if (lock_key != GP_UNLOCK_KEY)
        st_next.commit = GP_COMMIT_RST;
    end
    // commit only takes effect while the port is unlocked
    if (commit_wr && st_reg.unlocked)
      st_next.commit = commit_pins;

    // per-pin writes go through the pin mask and the protection filter
    tmask = gp_wr_mask(type_pins, st_reg.commit);
    pmask = gp_wr_mask(pad_pins, st_reg.commit);
    for (int i = 0; i < GP_PINS; i++)
    begin
      if (type_wr && tmask[i])
      begin
        st_next.mode[i] = gp_det_mode_t'(type_mode);
        st_next.disc[i] = type_discrete & GP_DISCRETE_CAP;
      end
      if (pad_wr && pmask[i])
      begin
        st_next.drive[i] = gp_drive_t'(pad_strength);
        st_next.ptype[i] = gp_pad_t'(pad_type);
      end
    end

    // status: raw view ignores enables, masked view honours them
    raw_all = {st_reg.dma_pend, raw_pin};
    masked  = raw_all & st_reg.ien;
    st_next.status = status_masked_sel ? masked : raw_all;

    // one port request; the controller's own enable sits outside
    st_next.port_irq = |masked;

    // discrete lines: each pin has its own; without discrete mode the
    // summary also rides on the pin 0 line
    disc_on = |st_reg.disc;
    if (GP_DISCRETE_CAP)
    begin
      st_next.pin_irq = masked[GP_PINS-1:0];
      if (!disc_on)
        st_next.pin_irq[0] = |masked;
    end
    else
    begin
      st_next.pin_irq = '0;
    end

    // pad controls: pulls act in any direction; drive, slew and
    // open-drain only matter for pins the port drives
    for (int i = 0; i < GP_PINS; i++)
    begin
      st_next.pu_en[i]   = (st_reg.ptype[i] == gp_pad_push_pull_pullup);
      st_next.pd_en[i]   = (st_reg.ptype[i] == gp_pad_push_pull_pulldown);
      st_next.an_en[i]   = (st_reg.ptype[i] == gp_pad_analog);
      st_next.wk_en[i]   = (st_reg.ptype[i] == gp_pad_wake_high)
                         | (st_reg.ptype[i] == gp_pad_wake_low);
      st_next.wk_high[i] = (st_reg.ptype[i] == gp_pad_wake_high);
      if (dir_in_mask[i])
      begin
        st_next.pad_drive[i] = 3'h0;
        st_next.slew_en[i]   = 1'b0;
        st_next.od_en[i]     = 1'b0;
      end
      else
      begin
        st_next.pad_drive[i] = st_reg.drive[i];
        st_next.slew_en[i]   = (st_reg.drive[i] == gp_drive_mid_slew_limited);
        st_next.od_en[i]     = (st_reg.ptype[i] == gp_pad_open_drain);
      end
    end

    // readback of one pin, answered on the next edge
    st_next.rd_valid = rd_req;
    if (rd_req)
    begin
      st_next.rd_strength = st_reg.drive[rd_pin];
      st_next.rd_pad_type = st_reg.ptype[rd_pin];
      st_next.rd_mode     = st_reg.mode[rd_pin];
      st_next.rd_discrete = st_reg.disc[rd_pin];
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_reg          <= '0;
      st_reg.ien      <= GP_IEN_RST;
      st_reg.commit   <= GP_COMMIT_RST;
      st_reg.mode     <= {GP_PINS{GP_MODE_RST}};
      st_reg.drive    <= {GP_PINS{GP_DRIVE_RST}};
      st_reg.ptype    <= {GP_PINS{GP_PAD_RST}};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // every output is a flop of the state register
  assign port_irq        = st_reg.port_irq;
  assign pin_irq         = st_reg.pin_irq;
  assign status_out      = st_reg.status;
  assign ien_out         = st_reg.ien;
  assign unlocked_out    = st_reg.unlocked;
  assign commit_out      = st_reg.commit;
  assign pad_drive_out   = st_reg.pad_drive;
  assign pad_slew_en     = st_reg.slew_en;
  assign pad_pullup_en   = st_reg.pu_en;
  assign pad_pulldown_en = st_reg.pd_en;
  assign pad_od_en       = st_reg.od_en;
  assign pad_analog_en   = st_reg.an_en;
  assign wake_en         = st_reg.wk_en;
  assign wake_sense_high = st_reg.wk_high;
  assign rd_valid        = st_reg.rd_valid;
  assign rd_strength     = st_reg.rd_strength;
  assign rd_pad_type     = st_reg.rd_pad_type;
  assign rd_mode         = st_reg.rd_mode;
  assign rd_discrete     = st_reg.rd_discrete;

endmodule

// [sim/gp_port_chk.sv]
`timescale 1ns/1ps
module gp_port_chk
  import gp_pkg::*;
(
  input wire logic            sys_clk,
  input wire logic            sys_rst,
  input wire logic [7:0]      dir_in_mask,
  input wire logic            dma_event,
  input wire logic            ien_set_wr,
  input wire logic            ien_clr_wr,
  input wire logic [8:0]      ien_flags,
  input wire logic            status_masked_sel,
  input wire logic            pad_wr,
  input wire logic [7:0]      pad_pins,
  input wire logic [2:0]      pad_strength,
  input wire logic [2:0]      pad_type,
  input wire logic            lock_wr,
  input wire logic [31:0]     lock_key,
  input wire logic            commit_wr,
  input wire logic            rd_req,
  input wire logic            port_irq,
  input wire logic [7:0]      pin_irq,
  input wire logic [8:0]      status_out,
  input wire logic [8:0]      ien_out,
  input wire logic            unlocked_out,
  input wire logic [7:0]      commit_out,
  input wire logic [7:0][2:0] pad_drive_out,
  input wire logic [7:0]      pad_od_en,
  input wire logic            rd_valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // pad write to pin 7 as open drain on an output pin, left alone for a cycle
  sequence s_pad_od;
    pad_wr && pad_pins[7] && pad_type == 3'h3 && !dir_in_mask[7];
  endsequence
  sequence s_pad_quiet;
    !(pad_wr && pad_pins[7]) && !dir_in_mask[7];
  endsequence

  AST_DMA_RAW: assert property (dma_event ##1 !status_masked_sel [*2] |-> status_out[8])
    else $error("dma event missing from raw status");
  AST_IEN_SET: assert property (ien_set_wr |=> (ien_out & $past(ien_flags)) == $past(ien_flags))
    else $error("enable set not stored");
  AST_IEN_CLR: assert property (ien_clr_wr && !ien_set_wr |=> (ien_out & $past(ien_flags)) == 9'h000)
    else $error("enable clear not stored");
  // masked view may only show enabled sources once enables have settled
  AST_MASKED: assert property (status_masked_sel && $past(status_masked_sel) && $stable(ien_out)
    |-> (status_out & ~ien_out) == 9'h000)
    else $error("masked status shows a disabled source");
  AST_LINE_PORT: assert property (pin_irq != 8'h00 |-> port_irq)
    else $error("pin line active without port request");
  AST_RD_VALID: assert property (rd_valid == $past(rd_req))
    else $error("readback strobe not one cycle after request");
  AST_UNLOCK: assert property (lock_wr && lock_key == GP_UNLOCK_KEY |=> unlocked_out)
    else $error("correct key did not unlock");
  AST_BADKEY: assert property (lock_wr && lock_key != GP_UNLOCK_KEY |=> !unlocked_out && commit_out == 8'h00)
    else $error("wrong key left port open");
  AST_COMMIT_REF: assert property (commit_wr && !unlocked_out && !lock_wr |=> $stable(commit_out))
    else $error("commit accepted while locked");
  AST_PAD_OD: assert property (s_pad_od ##1 s_pad_quiet |=> pad_od_en[7]
    && pad_drive_out[7] == $past(pad_strength, 2))
    else $error("pad setting not applied to output pin");
endmodule

bind gp_port gp_port_chk chk (.sys_clk, .sys_rst, .dir_in_mask, .dma_event, .ien_set_wr, .ien_clr_wr,
  .ien_flags, .status_masked_sel, .pad_wr, .pad_pins, .pad_strength, .pad_type, .lock_wr, .lock_key,
  .commit_wr, .rd_req, .port_irq, .pin_irq, .status_out, .ien_out, .unlocked_out, .commit_out,
  .pad_drive_out, .pad_od_en, .rd_valid);

// [sim/gp_pin_model.sv]
`timescale 1ns/1ps
module gp_pin_model
(
  input wire logic       sys_clk,
  input wire logic [7:0] level,
  input wire logic       freeze,
  input wire logic       slow,
  output logic [7:0]     pin_in
);
  logic [7:0] lag_reg;

  // slow mode adds a cycle of lag; pins never move while the detector is retyped
  always @(posedge sys_clk)
  begin
    lag_reg <= level;
    if (!freeze)
      pin_in <= slow ? lag_reg : level;
  end
endmodule

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
  import gp_pkg::*;
  logic            sys_clk, sys_rst, dma_event, ien_set_wr, ien_clr_wr, int_clr_wr, status_masked_sel, slow;
  logic            type_wr, type_discrete, pad_wr, lock_wr, commit_wr, rd_req, port_irq, rd_valid;
  logic            unlocked_out, rd_discrete, d;
  logic [7:0]      lvl, pin_in, dir_in_mask, type_pins, pad_pins, commit_pins, pin_irq, commit_out;
  logic [7:0]      pad_slew_en, pad_pullup_en, pad_pulldown_en, pad_od_en, pad_analog_en, wake_en, wake_sense_high;
  logic [8:0]      ien_flags, int_clr_flags, status_out, ien_out;
  logic [2:0]      type_mode, pad_strength, pad_type, rd_pin, rd_strength, rd_pad_type, rd_mode, s, t;
  logic [31:0]     lock_key;
  logic [7:0][2:0] pad_drive_out;
  logic [9:0]      exp_q[$];
  int              n_mismatch, n_compared;

  gp_pin_model ptr (.sys_clk, .level(lvl), .freeze(type_wr), .slow, .pin_in);
  gp_port dut (.sys_clk, .sys_rst, .pin_in, .dir_in_mask, .dma_event, .ien_set_wr, .ien_clr_wr, .ien_flags,
    .int_clr_wr, .int_clr_flags, .status_masked_sel, .type_wr, .type_pins, .type_mode, .type_discrete,
    .pad_wr, .pad_pins, .pad_strength, .pad_type, .lock_wr, .lock_key, .commit_wr, .commit_pins, .rd_req,
    .rd_pin, .port_irq, .pin_irq, .status_out, .ien_out, .unlocked_out, .commit_out, .pad_drive_out,
    .pad_slew_en, .pad_pullup_en, .pad_pulldown_en, .pad_od_en, .pad_analog_en, .wake_en, .wake_sense_high,
    .rd_valid, .rd_strength, .rd_pad_type, .rd_mode, .rd_discrete);

  // 200 MHz
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // inputs always move 1 ns after the edge, never on it
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic idle;
    {dma_event, ien_set_wr, ien_clr_wr, int_clr_wr, type_wr, pad_wr, lock_wr, commit_wr, rd_req} = 9'h000;
  endtask

  task automatic pad(input logic [7:0] p, input logic [2:0] st, input logic [2:0] ty);
    pad_pins = p;
    pad_strength = st;
    pad_type = ty;
    pad_wr = 1'b1;
    cyc(1);
    idle;
  endtask

  task automatic typ(input logic [7:0] p, input logic [2:0] m, input logic dsc);
    type_pins = p;
    type_mode = m;
    type_discrete = dsc;
    type_wr = 1'b1;
    cyc(1);
    idle;
  endtask

  // the expected readback waits in the queue until the strobe shows up
  task automatic rd(input logic [2:0] p, input logic [9:0] e);
    cyc(1);
    exp_q.push_back(e);
    rd_pin = p;
    rd_req = 1'b1;
    cyc(1);
    idle;
  endtask

  task automatic ien(input logic set, input logic [8:0] f);
    ien_set_wr = set;
    ien_clr_wr = !set;
    ien_flags = f;
    cyc(1);
    idle;
  endtask

  task automatic clr(input logic [8:0] f);
    int_clr_flags = f;
    int_clr_wr = 1'b1;
    cyc(1);
    idle;
  endtask

  task automatic stat(input logic sel, input logic [8:0] e);
    status_masked_sel = sel;
    cyc(2);
    chk(status_out, e);
  endtask

  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // readback watcher: oldest note against what the port returned
  always @(negedge sys_clk)
    if (rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(32'h0000_0001, 32'h0000_0000);
      else
        chk({rd_strength, rd_pad_type, rd_mode, rd_discrete}, exp_q.pop_front());
    end

  initial
  begin
    // 80,000 cycles at 5 ns; a hang counts as a mismatch
    #400_000;
    n_mismatch++;
    test_done;
  end

  initial
  begin
    n_mismatch = 0;
    n_compared = 0;
    {sys_rst, lvl, dir_in_mask, slow, status_masked_sel, lock_key} = {1'b1, 51'h0};
    {type_pins, pad_pins, commit_pins, type_mode, type_discrete, pad_strength, pad_type} = 34'h0;
    {rd_pin, ien_flags, int_clr_flags} = 21'h0;
    idle;
    void'($urandom(32'h4b1f6661));
    cyc(3);
    sys_rst = 1'b0;
    // locked pin 0 refuses, free pin 4 takes the same write
    pad(8'h11, 3'h3, 3'h3);
    rd(3'h0, 10'h000);
    rd(3'h4, {3'h3, 3'h3, 4'h0});
    lock_key = GP_UNLOCK_KEY;
    lock_wr = 1'b1;
    cyc(1);
    idle;
    commit_pins = 8'h01;
    commit_wr = 1'b1;
    cyc(1);
    idle;
    cyc(1);
    chk({unlocked_out, commit_out}, 9'h101);
    pad(8'h01, 3'h3, 3'h3);
    rd(3'h0, {3'h3, 3'h3, 4'h0});
    lock_key = 32'h0000_0000;
    lock_wr = 1'b1;
    cyc(1);
    idle;
    cyc(1);
    chk({unlocked_out, commit_out}, 9'h000);
    pad(8'h01, 3'h0, 3'h0);
    rd(3'h0, {3'h3, 3'h3, 4'h0});
    // every drive and pad code on pin 7, direction picked at random
    for (int i = 0; i < 7; i++)
    begin
      d = $urandom() % 2;
      dir_in_mask[7] = d;
      s = i;
      t = 6 - i;
      pad(8'h80, s, t);
      cyc(1);
      chk(pad_drive_out[7], d ? 3'h0 : s);
      chk(pad_slew_en[7], !d && s == 3'h3);
      chk({pad_od_en[7], pad_pullup_en[7], pad_pulldown_en[7], pad_analog_en[7]},
          {!d && t == 3'h3, t == 3'h1, t == 3'h2, t == 3'h4});
      chk({wake_en[7], wake_sense_high[7]}, {t == 3'h5 || t == 3'h6, t == 3'h5});
      rd(3'h7, {s, t, 4'h0});
    end
    // every detection mode, discrete flag toggling
    for (int m = 0; m < 5; m++)
    begin
      typ(8'hf0, m[2:0], m[0]);
      rd(3'h6, {6'h00, m[2:0], m[0]});
    end
    typ(8'hf0, gp_det_rise, 1'b0);
    // pin 5 enabled, pin 6 not; slow pins
    ien(1'b1, 9'h020);
    slow = 1'b1;
    lvl = 8'h60;
    cyc(7);
    stat(1'b0, 9'h060);
    chk({port_irq, pin_irq}, 9'h121);
    stat(1'b1, 9'h020);
    lvl = 8'h40;
    cyc(7);
    stat(1'b0, 9'h060);
    clr(9'h020);
    cyc(3);
    stat(1'b0, 9'h040);
    // a level source stays set through a clear while the level holds
    typ(8'h40, gp_det_high, 1'b0);
    clr(9'h040);
    cyc(4);
    stat(1'b0, 9'h040);
    lvl = 8'h00;
    cyc(7);
    stat(1'b0, 9'h000);
    // pin 5 on its own line, summary leaves line 0
    typ(8'h20, gp_det_rise, 1'b1);
    lvl = 8'h20;
    cyc(7);
    chk({port_irq, pin_irq}, 9'h120);
    clr(9'h020);
    cyc(5);
    chk({port_irq, pin_irq}, 9'h000);
    // dma source gated by its enable
    slow = 1'b0;
    ien(1'b1, 9'h100);
    dma_event = 1'b1;
    cyc(1);
    idle;
    cyc(2);
    chk({status_out[8], port_irq}, 2'b11);
    ien(1'b0, 9'h1ff);
    cyc(2);
    chk({status_out[8], port_irq, ien_out}, {2'b10, 9'h000});
    // dma bit cleared by its own mask bit
    clr(9'h100);
    cyc(3);
    chk(status_out[8], 1'b0);
    // falling-edge mode on pin 7: a rise leaves it quiet, the fall sets it
    typ(8'h80, gp_det_fall, 1'b0);
    lvl = 8'ha0;
    cyc(6);
    chk(status_out[7], 1'b0);
    lvl = 8'h20;
    cyc(6);
    chk(status_out[7], 1'b1);
    for (int i = 0; i < 8 && exp_q.size() > 0; i++)
      cyc(1);
    if (exp_q.size() > 0)
      n_mismatch++;
    test_done;
  end
endmodule
